// File: logic/paging_mode_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "paging_mode_regs.svh"

module paging_mode_control #(
	parameter bit HIGH_ADDR_LARGE_PAGE = 1'b1,
	parameter bit HUGE_PAGE_1G = 1'b1,
	parameter int LIN_WIDTH = 64
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic general_protection_fault_o,
	input wire paging_mode_pkg::lin_access_s access_i,
	output logic paging_on_o,
	output paging_mode_pkg::paging_mode_e mode_o,
	output paging_mode_pkg::modifiers_s modifiers_o,
	output logic [63:0] lin_addr_o,
	output logic [31:0] phys_addr_o,
	output logic translate_o,
	output logic canon_fault_o,
	output logic [31:0] root_o
);

	// The canonical and compatibility slices assume a full 64-bit linear bus
	if (LIN_WIDTH != 64)
	begin : g_bad_width
		$error("paging_mode_control supports only 64-bit linear addresses");
	end

	logic [31:0] control_reg_zero;
	logic [31:0] control_reg_four;
	logic [31:0] translation_root_reg;
	logic long_mode_enable;
	logic no_exec_enable;
	logic [31:0] extended_feature_reg;

	logic paging_enable;
	logic protection_enable;
	logic phys_addr_extension;
	logic long_mode_active;
	logic [31:0] next_cr0;
	logic [31:0] next_cr4;
	logic next_lme;
	logic fault_cr0;
	logic fault_cr4;
	logic fault_efer;

	// paging counts as on only under protection
	assign protection_enable = control_reg_zero[`CR0_PE_BIT];
	assign paging_enable = control_reg_zero[`CR0_PG_BIT] & protection_enable;
	assign phys_addr_extension = control_reg_four[`CR4_PAE_BIT];
	assign long_mode_active = paging_enable & long_mode_enable;

	always_comb
	begin
		extended_feature_reg = 32'h00000000;
		extended_feature_reg[`EFER_LME_BIT] = long_mode_enable;
		extended_feature_reg[`EFER_NXE_BIT] = no_exec_enable;
		extended_feature_reg[`EFER_LMA_BIT] = long_mode_active;
	end

	assign next_cr0 = wdata_i & `CR0_WMASK;
	assign next_cr4 = wdata_i & `CR4_WMASK;
	assign next_lme = wdata_i[`EFER_LME_BIT];

	// Enabling paging with no extension while long enable is set
	assign fault_cr0 = wr_i && addr_i == `SEL_CR_ZERO && next_cr0[`CR0_PG_BIT] && next_cr0[`CR0_PE_BIT]
		&& !control_reg_four[`CR4_PAE_BIT] && long_mode_enable;
	assign fault_cr4 = wr_i && addr_i == `SEL_CR_FOUR && long_mode_active
		&& !next_cr4[`CR4_PAE_BIT];
	assign fault_efer = wr_i && addr_i == `SEL_EXT_FEAT && paging_enable
		&& next_lme != long_mode_enable;

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			control_reg_zero <= `CR0_RESET;
		else if (wr_i && addr_i == `SEL_CR_ZERO && !fault_cr0)
			control_reg_zero <= next_cr0;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			control_reg_four <= `CR4_RESET;
		else if (wr_i && addr_i == `SEL_CR_FOUR && !fault_cr4)
			control_reg_four <= next_cr4;
	end

	// Bit 10 of a write is never stored; the status is always recomputed
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			long_mode_enable <= 1'b0;
			no_exec_enable <= 1'b0;
		end
		else if (wr_i && addr_i == `SEL_EXT_FEAT && !fault_efer)
		begin
			long_mode_enable <= next_lme;
			no_exec_enable <= wdata_i[`EFER_NXE_BIT];
		end
	end

	// Root register is only stored; loading it before paging is software's duty
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			translation_root_reg <= `ROOT_RESET;
		else if (wr_i && addr_i == `SEL_ROOT)
			translation_root_reg <= wdata_i;
	end

	assign root_o = translation_root_reg;

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			general_protection_fault_o <= 1'b0;
		else
			general_protection_fault_o <= fault_cr0 | fault_cr4 | fault_efer;
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_o <= 32'h00000000;
		else if (rd_i)
		begin
			case (addr_i)
				`SEL_CR_ZERO: rdata_o <= control_reg_zero;
				`SEL_CR_FOUR: rdata_o <= control_reg_four;
				`SEL_EXT_FEAT: rdata_o <= extended_feature_reg;
				`SEL_ROOT: rdata_o <= translation_root_reg;
				default: rdata_o <= 32'h00000000;
			endcase
		end
		else
			rdata_o <= 32'h00000000;
	end

	// Mode is combinational on the stored bits, so it applies to the access after the write
	always_comb
	begin
		mode_o = paging_mode_pkg::MODE_NONE;
		if (paging_enable)
		begin
			if (!phys_addr_extension)
				mode_o = paging_mode_pkg::MODE_LEGACY;
			else if (!long_mode_enable)
				mode_o = paging_mode_pkg::MODE_EXTENDED;
			else
				mode_o = paging_mode_pkg::MODE_LONG;
		end
	end

	assign paging_on_o = paging_enable;

	always_comb
	begin
		modifiers_o = '0;
		case (mode_o)
			paging_mode_pkg::MODE_LEGACY:
			begin
				modifiers_o.write_protect = control_reg_zero[`CR0_WP_BIT];
				modifiers_o.large_page = control_reg_four[`CR4_PSE_BIT];
				modifiers_o.global_page = control_reg_four[`CR4_PGE_BIT];
				modifiers_o.supervisor_exec_prevent = control_reg_four[`CR4_SUPERVISOR_EXEC_PREVENT_BIT];
				// Wide addresses only for 4 MB pages
				modifiers_o.high_addr_large_page = HIGH_ADDR_LARGE_PAGE
					& control_reg_four[`CR4_PSE_BIT];
			end
			paging_mode_pkg::MODE_EXTENDED:
			begin
				modifiers_o.write_protect = control_reg_zero[`CR0_WP_BIT];
				modifiers_o.global_page = control_reg_four[`CR4_PGE_BIT];
				modifiers_o.supervisor_exec_prevent = control_reg_four[`CR4_SUPERVISOR_EXEC_PREVENT_BIT];
				modifiers_o.exec_disable = no_exec_enable;
			end
			paging_mode_pkg::MODE_LONG:
			begin
				modifiers_o.write_protect = control_reg_zero[`CR0_WP_BIT];
				modifiers_o.global_page = control_reg_four[`CR4_PGE_BIT];
				modifiers_o.context_id = control_reg_four[`CR4_CONTEXT_ID_ENABLE_BIT];
				modifiers_o.supervisor_exec_prevent = control_reg_four[`CR4_SUPERVISOR_EXEC_PREVENT_BIT];
				modifiers_o.exec_disable = no_exec_enable;
				modifiers_o.huge_page_1g = HUGE_PAGE_1G;
			end
			default: modifiers_o = '0;
		endcase
	end

	// Canonical check: bits 63:47 must all match in 64-bit sub-mode
	logic canon_ok;
	assign canon_ok = &access_i.linear[63:`CANON_LSB] | ~|access_i.linear[63:`CANON_LSB];

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			lin_addr_o <= 64'h0000000000000000;
			phys_addr_o <= 32'h00000000;
			translate_o <= 1'b0;
			canon_fault_o <= 1'b0;
		end
		else
		begin
			translate_o <= 1'b0;
			canon_fault_o <= 1'b0;
			phys_addr_o <= 32'h00000000;
			if (access_i.valid)
			begin
				case (mode_o)
					paging_mode_pkg::MODE_NONE:
						phys_addr_o <= access_i.linear[`LEGACY_LIN_MSB:0];
					paging_mode_pkg::MODE_LEGACY,
					paging_mode_pkg::MODE_EXTENDED:
					begin
						lin_addr_o <= {32'h00000000, access_i.linear[`LEGACY_LIN_MSB:0]};
						translate_o <= 1'b1;
					end
					paging_mode_pkg::MODE_LONG:
					begin
						if (!access_i.long_64bit)
						begin
							lin_addr_o <= {32'h00000000, access_i.linear[`LEGACY_LIN_MSB:0]};
							translate_o <= 1'b1;
						end
						else if (canon_ok)
						begin
							lin_addr_o <= {16'h0000, access_i.linear[`CANON_LSB:0]};
							translate_o <= 1'b1;
						end
						else
							canon_fault_o <= 1'b1;
					end
					default: translate_o <= 1'b0;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// File: include/paging_mode_regs.svh
`ifndef PAGING_MODE_REGS_SVH
`define PAGING_MODE_REGS_SVH

// Register selectors on the software port
`define SEL_CR_ZERO 2'h0
`define SEL_CR_FOUR 2'h1
`define SEL_EXT_FEAT 2'h2
`define SEL_ROOT 2'h3

// Control register zero
`define CR0_PE_BIT 0
`define CR0_WP_BIT 16
`define CR0_PG_BIT 31
// Control register four
`define CR4_PSE_BIT 4
`define CR4_PAE_BIT 5
`define CR4_PGE_BIT 7
`define CR4_CONTEXT_ID_ENABLE_BIT 17
`define CR4_SUPERVISOR_EXEC_PREVENT_BIT 20
// Extended feature register
`define EFER_LME_BIT 8
`define EFER_LMA_BIT 10
`define EFER_NXE_BIT 11

`define CR0_RESET 32'h00000000
`define CR4_RESET 32'h00000000
`define EFER_RESET 32'h00000000
`define ROOT_RESET 32'h00000000

// Writable masks; everything else reads as zero, but extended feature bit 10 reads long mode active
`define CR0_WMASK 32'h80010001
`define CR4_WMASK 32'h001200b0
`define EFER_WMASK 32'h00000900

`define LEGACY_LIN_MSB 31
`define COMPAT_HI_MSB 47
`define COMPAT_HI_LSB 32
`define CANON_LSB 47
`define PROC_ID_BITS 12

`endif

// File: include/paging_mode_pkg.sv
package paging_mode_pkg;

	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_LEGACY,
		MODE_EXTENDED,
		MODE_LONG
	} paging_mode_e;

	typedef struct packed {
		logic write_protect;
		logic large_page;
		logic global_page;
		logic context_id;
		logic supervisor_exec_prevent;
		logic exec_disable;
		logic high_addr_large_page;
		logic huge_page_1g;
	} modifiers_s;

	typedef struct packed {
		logic valid;
		logic [63:0] linear;
		logic long_64bit;
	} lin_access_s;

endpackage

// File: dv/paging_mode_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module paging_mode_monitor (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic general_protection_fault_o,
	input wire paging_mode_pkg::lin_access_s access_i,
	input wire logic paging_on_o,
	input wire paging_mode_pkg::paging_mode_e mode_o,
	input wire paging_mode_pkg::modifiers_s modifiers_o,
	input wire logic [31:0] phys_addr_o,
	input wire logic canon_fault_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	wire logic lng = mode_o == paging_mode_pkg::MODE_LONG;
	wire logic [16:0] top = access_i.linear[63:47];
	off_mode_a: assert property (!paging_on_o |-> mode_o == paging_mode_pkg::MODE_NONE && modifiers_o == '0)
		else $error("mode or modifiers live with paging off");
	pass_thru_a: assert property (access_i.valid && !paging_on_o |=> phys_addr_o == $past(access_i.linear[31:0]))
		else $error("physical address differs from linear");
	legacy_mods_a: assert property (mode_o == paging_mode_pkg::MODE_LEGACY |-> !modifiers_o.exec_disable && !modifiers_o.context_id)
		else $error("legacy mode honours a foreign modifier");
	ext_mods_a: assert property (mode_o == paging_mode_pkg::MODE_EXTENDED |-> !modifiers_o.large_page && !modifiers_o.context_id)
		else $error("extended mode honours a foreign modifier");
	lma_read_a: assert property (rd_i && addr_i == 2'h2 && lng |=> rdata_o[10])
		else $error("long mode active bit low in long mode");
	canon_hit_a: assert property (access_i.valid && access_i.long_64bit && lng && !(&top || ~|top) |=> canon_fault_o)
		else $error("non canonical address not flagged");
	canon_off_a: assert property (access_i.valid && !lng |=> !canon_fault_o)
		else $error("canonical fault outside long mode");
	quiet_fault_a: assert property (!wr_i |=> !general_protection_fault_o)
		else $error("fault without a write");
	lme_lock_a: assert property (wr_i && addr_i == 2'h2 && lng && !wdata_i[8] |=> general_protection_fault_o)
		else $error("long mode enable cleared with paging on");
	pae_lock_a: assert property (wr_i && addr_i == 2'h1 && lng && !wdata_i[5] |=> general_protection_fault_o)
		else $error("extension cleared in long paging");
	long_c: cover property (lng);
	fault_c: cover property (general_protection_fault_o);
	canon_c: cover property (canon_fault_o);
endmodule
bind paging_mode_control paging_mode_monitor u_mon (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.general_protection_fault_o(general_protection_fault_o), .access_i(access_i), .paging_on_o(paging_on_o),
	.mode_o(mode_o), .modifiers_o(modifiers_o), .phys_addr_o(phys_addr_o), .canon_fault_o(canon_fault_o));
`default_nettype wire

// File: dv/paging_mode_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "paging_mode_regs.svh"
module paging_mode_control_tb;
	logic mclk_i = '0;
	logic nrst_i = '0;
	logic [1:0] addr_i = '0;
	logic [31:0] wdata_i = '0;
	logic wr_i = '0;
	logic rd_i = '0;
	paging_mode_pkg::lin_access_s access_i = '0;
	logic [31:0] rdata_o;
	logic [31:0] phys_addr_o;
	logic gpf;
	logic canon_fault_o;
	logic translate_o;
	logic [63:0] lin_addr_o;
	logic paging_on_o;
	logic [31:0] root_o;
	logic [64:0] tq[$];
	paging_mode_pkg::paging_mode_e mode_o;
	paging_mode_pkg::modifiers_s modifiers_o;
	int n_errors = 0;
	int n_checks = 0;
	logic [31:0] rq[$];
	logic fq[$];
	logic [32:0] aq[$];
	logic [31:0] seed = 32'hdc0b;
	logic rd_d = '0;
	logic wr_d = '0;
	logic ac_d = '0;
	// Read-back masks; paging enable kept off while random data goes in
	localparam logic [31:0] WM[4] = '{`CR0_WMASK & 32'h7fffffff, `CR4_WMASK, `EFER_WMASK, 32'hffffffff};
	paging_mode_control DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .general_protection_fault_o(gpf), .access_i(access_i),
		.paging_on_o(paging_on_o), .mode_o(mode_o), .modifiers_o(modifiers_o), .lin_addr_o(lin_addr_o),
		.phys_addr_o(phys_addr_o), .translate_o(translate_o), .canon_fault_o(canon_fault_o), .root_o(root_o));
	initial forever #20 mclk_i = ~mclk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'h0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [65:0] s, input logic [65:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge mclk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		access_i.valid <= 1'h0;
		if (w)
			fq.push_back(e[0]);
		else
			rq.push_back(e);
	endtask
	task automatic acc(input logic [63:0] l, input logic b, input logic [32:0] e, input logic [64:0] t);
		@(posedge mclk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
		access_i <= '{1'h1, l, b};
		aq.push_back(e);
		tq.push_back(t);
	endtask
	task automatic idle;
		@(posedge mclk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
		access_i.valid <= 1'h0;
		@(negedge mclk_i);
	endtask
	task automatic mc(input paging_mode_pkg::paging_mode_e m, input logic [7:0] f);
		idle();
		chk(mode_o, m);
		chk(paging_on_o, m != paging_mode_pkg::MODE_NONE);
		chk(modifiers_o & 8'hfc, f);
	endtask
	always @(posedge mclk_i)
	begin
		rd_d <= rd_i;
		wr_d <= wr_i;
		ac_d <= access_i.valid;
		if (rd_d)
			chk(rdata_o, rq.pop_front());
		if (wr_d)
			chk(gpf, fq.pop_front());
		if (ac_d)
		begin
			chk({canon_fault_o, phys_addr_o}, aq.pop_front());
			chk({translate_o, lin_addr_o}, tq.pop_front());
		end
	end
	initial
	begin
		#200000;
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'h1;
		for (int i = 0; i < 4; i++)
			bus(1'h0, i[1:0], 32'h0, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			bus(1'h1, i[1:0], seed & WM[0 - 0 + (i == 0 ? 0 : 3)] | seed & ~32'h80000000 & WM[i], 32'h0);
			bus(1'h0, i[1:0], 32'h0, seed & WM[i]);
		end
		idle();
		chk(root_o, seed);
		bus(1'h1, 2'h1, 32'hffffffff, 32'h0);
		bus(1'h1, 2'h2, 32'h00000900, 32'h0);
		bus(1'h1, 2'h0, 32'h00010001, 32'h0);
		mc(paging_mode_pkg::MODE_NONE, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			acc({seed, ~seed}, seed[0], {1'h0, ~seed}, 65'h0);
		end
		bus(1'h1, 2'h2, 32'h0, 32'h0);
		bus(1'h1, 2'h1, 32'h0, 32'h0);
		bus(1'h1, 2'h0, 32'h80000000, 32'h0);
		mc(paging_mode_pkg::MODE_NONE, 8'h00);
		bus(1'h1, 2'h0, 32'h0, 32'h0);
		bus(1'h1, 2'h2, 32'h00000100, 32'h0);
		bus(1'h1, 2'h0, 32'h80000001, 32'h1);
		bus(1'h0, 2'h0, 32'h0, 32'h0);
		mc(paging_mode_pkg::MODE_NONE, 8'h00);
		bus(1'h1, 2'h2, 32'h0, 32'h0);
		bus(1'h1, 2'h1, 32'h00120090, 32'h0);
		bus(1'h1, 2'h0, 32'h80010001, 32'h0);
		mc(paging_mode_pkg::MODE_LEGACY, 8'he8);
		bus(1'h1, 2'h2, 32'h00000800, 32'h0);
		acc(64'h1234, 1'h0, 33'h0, {1'h1, 64'h1234});
		mc(paging_mode_pkg::MODE_LEGACY, 8'he8);
		bus(1'h1, 2'h1, 32'h001200b0, 32'h0);
		mc(paging_mode_pkg::MODE_EXTENDED, 8'hac);
		bus(1'h1, 2'h2, 32'h00000900, 32'h1);
		bus(1'h0, 2'h2, 32'h0, 32'h00000800);
		bus(1'h1, 2'h1, 32'h00000020, 32'h0);
		bus(1'h1, 2'h0, 32'h00000001, 32'h0);
		bus(1'h1, 2'h2, 32'h00000900, 32'h0);
		bus(1'h1, 2'h0, 32'h80010001, 32'h0);
		bus(1'h1, 2'h1, 32'h001200b0, 32'h0);
		mc(paging_mode_pkg::MODE_LONG, 8'hbc);
		bus(1'h0, 2'h2, 32'h0, 32'h00000d00);
		bus(1'h1, 2'h1, 32'h00120090, 32'h1);
		bus(1'h1, 2'h2, 32'h00000800, 32'h1);
		mc(paging_mode_pkg::MODE_LONG, 8'hbc);
		// Bit 47 set with zero above it is the smallest non canonical case
		acc(64'h0000800000000000, 1'h1, {1'h1, 32'h0}, {1'h0, 64'h1234});
		acc(64'hffff800000001000, 1'h1, 33'h0, {1'h1, 64'h0000800000001000});
		acc(64'h0000800000000000, 1'h0, 33'h0, {1'h1, 64'h0});
		idle();
		idle();
		end_of_test();
	end
endmodule
`default_nettype wire
